// ### rtl/ocs_pkg.sv
package ocs_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FORCE_MIN     = 5;
  localparam int FORCE_TICKS   = FORCE_MIN * 60 * 1000;
  localparam int LOAD_S        = 1;
  localparam int LOAD_TICKS    = LOAD_S * 1000;
  localparam int NGRP          = 4;
  localparam int NREC          = 8;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_SCALE    = 8'h04;
  localparam logic [7:0] A_FORCE    = 8'h08;
  localparam logic [7:0] A_STATUS   = 8'h0c;
  localparam logic [7:0] A_IRQ_STAT = 8'h10;
  localparam logic [7:0] A_IRQ_MASK = 8'h14;
  localparam logic [7:0] A_CNT_CLR  = 8'h18;
  localparam logic [7:0] A_MAXCUR   = 8'h1c;
  localparam logic [7:0] A_NOM      = 8'h20;
  localparam logic [7:0] A_REC_SEL  = 8'h24;
  localparam logic [7:0] A_REC_TIME = 8'h28;
  localparam logic [7:0] A_REC_INFO = 8'h2c;
  localparam logic [7:0] A_REC_FLT  = 8'h30;
  localparam logic [7:0] A_REC_LOAD = 8'h34;
  localparam logic [1:0] R_PICKUP   = 2'h1;
  localparam logic [1:0] R_OPTIME   = 2'h2;
  localparam logic [1:0] R_STAGE    = 2'h3;

  localparam int CTRL_FORCE = 0;
  localparam int CTRL_SCALE = 1;
  localparam int CTRL_MGRP  = 2;
  localparam int CTRL_AGRP  = 4;
  localparam int CTRL_SRC   = 6;
  localparam int CTRL_IDX   = 9;
  localparam int CTRL_HARM  = 12;
  localparam int IRQ_START  = 0;
  localparam int IRQ_TRIP   = 4;
  localparam int IRQ_FTO    = 8;

  localparam logic [7:0]  SCALE_RST = 8'h64;
  localparam logic [7:0]  SCALE_MIN = 8'h0a;
  localparam logic [7:0]  SCALE_MAX = 8'hc8;
  localparam logic [7:0]  PCT_FULL  = 8'h64;
  localparam logic [15:0] PK_RST    = 16'h00c8;
  localparam logic [15:0] OP_RST    = 16'h0064;
  localparam logic [15:0] NOM_RST   = 16'h0064;

  typedef enum logic [2:0] {
    SRC_NONE = 3'b000, SRC_DI = 3'b001, SRC_VI = 3'b010, SRC_LED = 3'b011, SRC_VO = 3'b100
  } grp_src_t;

  typedef enum logic [2:0] {
    FT_NONE = 3'b000, FT_1N = 3'b001, FT_2N = 3'b010, FT_3N = 3'b011,
    FT_12 = 3'b100, FT_23 = 3'b101, FT_31 = 3'b110, FT_123 = 3'b111
  } fault_type_t;
endpackage

// ### rtl/phase_max.sv
module phase_max
  import ocs_pkg::*;
#(
  parameter int CW = 16
)(
  input  wire logic            i_clk,     // System clock
  input  wire logic            i_sys_rst, // Async reset, active high
  input  wire logic            i_harm,    // 1: include harmonics
  input  wire logic [3*CW-1:0] i_fund,    // Fundamental magnitudes
  input  wire logic [3*CW-1:0] i_rms,     // True rms magnitudes
  output logic      [CW-1:0]   o_max,     // Largest phase current
  output logic      [3*CW-1:0] o_phase    // Selected phase currents
);
  logic [3*CW-1:0] sel;
  logic [CW-1:0]   m01;
  logic [CW-1:0]   mall;

  assign sel  = i_harm ? i_rms : i_fund;
  assign m01  = (sel[CW-1:0] > sel[2*CW-1:CW]) ? sel[CW-1:0] : sel[2*CW-1:CW];
  assign mall = (m01 > sel[3*CW-1:2*CW]) ? m01 : sel[3*CW-1:2*CW];

  always_ff @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      o_max   <= '0;
      o_phase <= '0;
    end
    else
    begin
      o_max   <= mall;
      o_phase <= sel;
    end
endmodule

// ### rtl/overcurrent_stages.sv
// Summary of operation
// - Test force flag clears after five idle minutes
// - Status forcing writes accepted only while forcing
// - Per-stage start and trip counters, clearable
// - Four setting groups, selectable by chosen source
// - Supervised value is largest phase current
// - Each stage reports blocked, started, tripped
// - Pick-up in amperes from setting, nominal
// - Eight latest fault records kept
// - Fault type coded from faulted phases
// - Load is one second average before fault
// - Elapsed delay in percent, trip is 100
// - Scaling factor 100 or 10 to 200
// - Enabling scaling copies group one, scaled
// - Scaling switches active group to two
// - Scaling factor counts one percent each
module overcurrent_stages
  import ocs_pkg::*;
#(
  parameter int NS              = 3,
  parameter int CW              = 16,
  parameter int TICK_CYCLES     = TICK_CYC,
  parameter int FORCE_TMO_TICKS = FORCE_TICKS
)(
  input  wire logic            i_clk,                // System clock, 20 MHz
  input  wire logic            i_sys_rst,            // Async reset, active high
  input  wire logic [7:0]      i_addr,               // Register byte address
  input  wire logic [31:0]     i_wdata,              // Write data
  input  wire logic            i_wr,                 // Write strobe
  input  wire logic            i_rd,                 // Read strobe
  output logic      [31:0]     o_rdata,              // Read data, cycle after read
  input  wire logic [3*CW-1:0] i_phase_fund,         // Phase 1..3 fundamental, A
  input  wire logic [3*CW-1:0] i_phase_rms,          // Phase 1..3 with harmonics, A
  input  wire logic [NS-1:0]   i_block,              // Stage block inputs
  input  wire logic            i_panel_press,        // Front panel key pressed
  input  wire logic [7:0]      i_digital_input_n,    // Digital inputs
  input  wire logic [7:0]      i_virtual_input_n,    // Virtual inputs
  input  wire logic [7:0]      i_indicator_signal_n, // Indicator signals
  input  wire logic [7:0]      i_virtual_output_n,   // Virtual outputs
  input  wire logic [31:0]     i_timestamp,          // Time of day stamp
  output logic      [NS-1:0]   o_blocked,            // Stage blocked
  output logic      [NS-1:0]   o_start,              // Stage started
  output logic      [NS-1:0]   o_trip,               // Stage tripped
  output logic      [1:0]      o_active_group,       // Active group, 0 = group one
  output logic                 o_force_flag,         // Test forcing enabled
  output logic                 o_irq                 // Interrupt, level
);
  localparam int TW = $clog2(TICK_CYCLES);
  localparam int FW = $clog2(FORCE_TMO_TICKS + 1);
  localparam int LW = $clog2(LOAD_TICKS + 1);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [CW-1:0] prim(input logic [15:0] pk, input logic [CW-1:0] nom);
    logic [47:0] p;
    p = (48'(pk) * 48'(nom)) / 48'h64;
    prim = (p > 48'({CW{1'b1}})) ? '1 : p[CW-1:0];
  endfunction

  function automatic logic [15:0] scale_pk(input logic [15:0] pk, input logic [7:0] f);
    logic [23:0] p;
    p = (24'(pk) * 24'(f)) / 24'h64;
    scale_pk = (p > 24'h00ffff) ? 16'hffff : p[15:0];
  endfunction

  function automatic fault_type_t ftype(input logic [2:0] m);
    case (m)
      3'h1:    ftype = FT_1N;
      3'h2:    ftype = FT_2N;
      3'h4:    ftype = FT_3N;
      3'h3:    ftype = FT_12;
      3'h6:    ftype = FT_23;
      3'h5:    ftype = FT_31;
      3'h7:    ftype = FT_123;
      default: ftype = FT_NONE;
    endcase
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [15:0]   ctrl_q;
  logic          force_q;
  logic [7:0]    fac_q;
  logic [NS-1:0] fst_q, ftr_q;
  logic [8:0]    ist_q, imsk_q;
  logic [CW-1:0] nom_q;
  logic [2:0]    rsel_q;
  logic [1:0]    grp_q;
  logic          scl_q;
  logic [TW-1:0] tcnt_q;
  logic [FW-1:0] fcnt_q;
  logic [15:0]   pk_q [NGRP][NS];
  logic [15:0]   op_q [NGRP][NS];
  logic [NS-1:0] st_q, tr_q, blk_q;
  logic [15:0]   tmr_q [NS];
  logic [CW-1:0] pkc_q [NS];
  logic [2:0]    msk_q [NS];
  logic [15:0]   scnt_q [NS];
  logic [15:0]   tcnt_s_q [NS];
  logic [CW+LW-1:0] lsum_q;
  logic [LW-1:0] lcnt_q;
  logic [CW-1:0] lavg_q;
  logic [31:0]   rt_q [NREC];
  logic [15:0]   ri_q [NREC];
  logic [CW-1:0] rf_q [NREC];
  logic [CW-1:0] rl_q [NREC];
  logic [2:0]    wp_q;
  logic [31:0]   rd_q;

  logic          tick, renew, fto, wr_ctrl, fac_ok, copy;
  logic [7:0]    fac_new;
  logic [1:0]    grp_d, eg, es;
  logic [7:0]    sel_vec;
  logic          sel_on;
  logic [CW-1:0] mx_a [NS];
  logic [2:0]    pm_a [NS];
  logic [CW-1:0] pka_a [NS];
  logic [NS-1:0] st_raw, tr_raw, s_ev, t_ev, trig;
  logic          rec_hit;
  logic [1:0]    rec_s;
  logic [7:0]    edly;
  logic [23:0]   eq;
  logic [8:0]    ev;
  logic [31:0]   rd_d;
  logic [2:0]    rix;

  assign wr_ctrl = i_wr && (i_addr == A_CTRL);
  assign fac_ok  = i_wr && (i_addr == A_SCALE) && (i_wdata[7:0] >= SCALE_MIN) && (i_wdata[7:0] <= SCALE_MAX);
  assign fac_new = fac_ok ? i_wdata[7:0] : fac_q;
  assign copy    = (ctrl_q[CTRL_SCALE] && !scl_q) || (fac_ok && scl_q);
  assign eg      = i_addr[5:4];
  assign es      = i_addr[3:2];

  // ****************************************
  // Millisecond tick and test forcing
  // ****************************************
  assign tick  = (tcnt_q == TW'(TICK_CYCLES - 1));
  assign renew = (wr_ctrl && i_wdata[CTRL_FORCE]) || (force_q && i_panel_press);
  assign fto   = force_q && tick && (fcnt_q == FW'(FORCE_TMO_TICKS - 1)) && !renew;

  always_ff @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
      tcnt_q <= '0;
    else
      tcnt_q <= tick ? '0 : tcnt_q + 1'b1;

  always_ff @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      force_q <= 1'b0;
      fcnt_q  <= '0;
    end
    else
    begin
      if (renew)
        fcnt_q <= '0;
      else if (force_q && tick)
        fcnt_q <= fcnt_q + 1'b1;
      if (wr_ctrl)
        force_q <= i_wdata[CTRL_FORCE];
      else if (fto)
        force_q <= 1'b0;
    end

  // Forced bits drop with the flag so a stale test state never lingers
  always_ff @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      fst_q <= '0;
      ftr_q <= '0;
    end
    else if (!force_q)
    begin
      fst_q <= '0;
      ftr_q <= '0;
    end
    else if (i_wr && i_addr == A_FORCE)
    begin
      fst_q <= i_wdata[NS-1:0];
      ftr_q <= i_wdata[4+NS-1:4];
    end

  // ****************************************
  // Configuration and setting groups
  // ****************************************
  always_ff @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      ctrl_q <= '0;
      fac_q  <= SCALE_RST;
      nom_q  <= CW'(NOM_RST);
      rsel_q <= '0;
      imsk_q <= '0;
      scl_q  <= 1'b0;
      grp_q  <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= {i_wdata[15:1], 1'b0};
      if (fac_ok)
        fac_q <= i_wdata[7:0];
      if (i_wr && i_addr == A_NOM)
        nom_q <= i_wdata[CW-1:0];
      if (i_wr && i_addr == A_REC_SEL)
        rsel_q <= i_wdata[2:0];
      if (i_wr && i_addr == A_IRQ_MASK)
        imsk_q <= i_wdata[8:0];
      scl_q <= ctrl_q[CTRL_SCALE];
      grp_q <= grp_d;
    end

  always_comb
  begin
    case (grp_src_t'(ctrl_q[CTRL_SRC+:3]))
      SRC_DI:  sel_vec = i_digital_input_n;
      SRC_VI:  sel_vec = i_virtual_input_n;
      SRC_LED: sel_vec = i_indicator_signal_n;
      SRC_VO:  sel_vec = i_virtual_output_n;
      default: sel_vec = 8'h00;
    endcase
    sel_on = sel_vec[ctrl_q[CTRL_IDX+:3]];
    grp_d  = sel_on ? ctrl_q[CTRL_AGRP+:2] : ctrl_q[CTRL_MGRP+:2];
    if (ctrl_q[CTRL_SCALE])
      grp_d = 2'h1;
  end

  // Copy wins over a same-cycle settings write into group two
  always_ff @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      for (int g = 0; g < NGRP; g++)
        for (int k = 0; k < NS; k++)
        begin
          pk_q[g][k] <= PK_RST;
          op_q[g][k] <= OP_RST;
        end
    end
    else if (copy)
    begin
      for (int k = 0; k < NS; k++)
      begin
        pk_q[1][k] <= scale_pk(pk_q[0][k], fac_new);
        op_q[1][k] <= op_q[0][k];
      end
    end
    else if (i_wr && es < NS)
    begin
      if (i_addr[7:6] == R_PICKUP)
        pk_q[eg][es] <= i_wdata[15:0];
      else if (i_addr[7:6] == R_OPTIME)
        op_q[eg][es] <= i_wdata[15:0];
    end

  // ****************************************
  // Stages
  // ****************************************
  for (genvar s = 0; s < NS; s++)
  begin : g_st
    logic [CW-1:0]   mx;
    logic [3*CW-1:0] ph;
    phase_max #(.CW(CW)) u_max (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_harm    (ctrl_q[CTRL_HARM+s]),
      .i_fund    (i_phase_fund),
      .i_rms     (i_phase_rms),
      .o_max     (mx),
      .o_phase   (ph)
    );
    assign mx_a[s]  = mx;
    assign pka_a[s] = prim(pk_q[grp_q][s], nom_q);
    for (genvar p = 0; p < 3; p++)
    begin : g_ph
      assign pm_a[s][p] = ph[p*CW+:CW] > pka_a[s];
    end
    assign st_raw[s] = !i_block[s] && (mx > pka_a[s]);
    assign tr_raw[s] = st_raw[s] && (tmr_q[s] >= op_q[grp_q][s]);
    assign s_ev[s]   = st_raw[s] && !st_q[s];
    assign t_ev[s]   = tr_raw[s] && !tr_q[s];
    assign trig[s]   = t_ev[s] || (st_q[s] && !st_raw[s] && !tr_q[s]);
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      st_q  <= '0;
      tr_q  <= '0;
      blk_q <= '0;
      for (int k = 0; k < NS; k++)
      begin
        tmr_q[k] <= '0;
        pkc_q[k] <= '0;
        msk_q[k] <= '0;
      end
    end
    else
    begin
      st_q  <= st_raw;
      tr_q  <= tr_raw;
      blk_q <= i_block;
      for (int k = 0; k < NS; k++)
      begin
        if (!st_raw[k])
          tmr_q[k] <= '0;
        else if (tick && tmr_q[k] != 16'hffff)
          tmr_q[k] <= tmr_q[k] + 1'b1;
        if (!st_q[k])
        begin
          pkc_q[k] <= mx_a[k];
          msk_q[k] <= pm_a[k];
        end
        else
        begin
          if (mx_a[k] > pkc_q[k])
            pkc_q[k] <= mx_a[k];
          msk_q[k] <= msk_q[k] | pm_a[k];
        end
      end
    end

  // An event in the clearing cycle leaves the counter at one
  always_ff @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      for (int k = 0; k < NS; k++)
      begin
        scnt_q[k]   <= '0;
        tcnt_s_q[k] <= '0;
      end
    end
    else
    begin
      for (int k = 0; k < NS; k++)
      begin
        if (i_wr && i_addr == A_CNT_CLR && i_wdata[k])
          scnt_q[k] <= {15'h0000, s_ev[k]};
        else if (s_ev[k])
          scnt_q[k] <= scnt_q[k] + 1'b1;
        if (i_wr && i_addr == A_CNT_CLR && i_wdata[4+k])
          tcnt_s_q[k] <= {15'h0000, t_ev[k]};
        else if (t_ev[k])
          tcnt_s_q[k] <= tcnt_s_q[k] + 1'b1;
      end
    end

  assign o_blocked      = blk_q;
  assign o_start        = st_q | fst_q;
  assign o_trip         = tr_q | ftr_q;
  assign o_active_group = grp_q;
  assign o_force_flag   = force_q;

  // ****************************************
  // Load average and fault records
  // ****************************************
  // Block average over fixed one second windows, from stage one's supervised value
  always_ff @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      lsum_q <= '0;
      lcnt_q <= '0;
      lavg_q <= '0;
    end
    else if (tick)
    begin
      if (lcnt_q == LW'(LOAD_TICKS - 1))
      begin
        lcnt_q <= '0;
        lsum_q <= '0;
        lavg_q <= CW'((lsum_q + (CW+LW)'(mx_a[0])) / (CW+LW)'(LOAD_TICKS));
      end
      else
      begin
        lcnt_q <= lcnt_q + 1'b1;
        lsum_q <= lsum_q + (CW+LW)'(mx_a[0]);
      end
    end

  always_comb
  begin
    rec_hit = 1'b0;
    rec_s   = '0;
    for (int k = NS - 1; k >= 0; k--)
      if (trig[k])
      begin
        rec_hit = 1'b1;
        rec_s   = 2'(k);
      end
    eq = (op_q[grp_q][rec_s] == 16'h0000) ? 24'h000064 :
         (24'(tmr_q[rec_s]) * 24'h000064) / 24'(op_q[grp_q][rec_s]);
    edly = (t_ev[rec_s] || eq >= 24'h000064) ? PCT_FULL : eq[7:0];
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      wp_q <= '0;
      for (int r = 0; r < NREC; r++)
      begin
        rt_q[r] <= '0;
        ri_q[r] <= '0;
        rf_q[r] <= '0;
        rl_q[r] <= '0;
      end
    end
    else if (rec_hit)
    begin
      wp_q       <= wp_q + 1'b1;
      rt_q[wp_q] <= i_timestamp;
      ri_q[wp_q] <= {1'b0, grp_q, rec_s, ftype(msk_q[rec_s] | pm_a[rec_s]), edly};
      rf_q[wp_q] <= (mx_a[rec_s] > pkc_q[rec_s]) ? mx_a[rec_s] : pkc_q[rec_s];
      rl_q[wp_q] <= lavg_q;
    end

  // ****************************************
  // Interrupts and read port
  // ****************************************
  assign ev = {fto, 4'(t_ev), 4'(s_ev)};

  always_ff @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
      ist_q <= '0;
    else
      ist_q <= (ist_q & ~((i_wr && i_addr == A_IRQ_STAT) ? i_wdata[8:0] : 9'h000)) | ev;

  assign o_irq = |(ist_q & imsk_q);
  assign rix   = wp_q - 3'h1 - rsel_q;

  always_comb
  begin
    rd_d = 32'h0000_0000;
    case (i_addr)
      A_CTRL:     rd_d = {16'h0000, ctrl_q[15:1], force_q};
      A_SCALE:    rd_d = {24'h000000, fac_q};
      A_FORCE:    rd_d = 32'(fst_q) | (32'(ftr_q) << 4);
      A_STATUS:   rd_d = 32'(o_start) | (32'(o_trip) << 4) | (32'(blk_q) << 8) | (32'(grp_q) << 12);
      A_IRQ_STAT: rd_d = 32'(ist_q);
      A_IRQ_MASK: rd_d = 32'(imsk_q);
      A_MAXCUR:   rd_d = 32'(mx_a[0]);
      A_NOM:      rd_d = 32'(nom_q);
      A_REC_SEL:  rd_d = 32'(rsel_q);
      A_REC_TIME: rd_d = rt_q[rix];
      A_REC_INFO: rd_d = 32'(ri_q[rix]);
      A_REC_FLT:  rd_d = 32'(rf_q[rix]);
      A_REC_LOAD: rd_d = 32'(rl_q[rix]);
      default:
        if (es < NS)
        begin
          if (i_addr[7:6] == R_PICKUP)
            rd_d = 32'(pk_q[eg][es]);
          else if (i_addr[7:6] == R_OPTIME)
            rd_d = 32'(op_q[eg][es]);
          else if (i_addr[7:6] == R_STAGE && eg == 2'h0)
            rd_d = 32'(scnt_q[es]);
          else if (i_addr[7:6] == R_STAGE && eg == 2'h1)
            rd_d = 32'(tcnt_s_q[es]);
          else if (i_addr[7:6] == R_STAGE && eg == 2'h2)
            rd_d = 32'(pka_a[es]);
        end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
      rd_q <= '0;
    else
      rd_q <= i_rd ? rd_d : 32'h0000_0000;

  assign o_rdata = rd_q;

  // ****************************************
  // Checks
  // ****************************************
  property p_force_tmo;
    @(posedge i_clk) disable iff (i_sys_rst) fto |=> !force_q;
  endproperty
  a_force_tmo: assert property (p_force_tmo) else $error("force flag kept after timeout");

  property p_force_rej;
    @(posedge i_clk) disable iff (i_sys_rst) (!force_q && i_wr && i_addr == A_FORCE) |=> (fst_q == '0 && ftr_q == '0);
  endproperty
  a_force_rej: assert property (p_force_rej) else $error("forcing accepted without flag");

  property p_cnt_clr;
    @(posedge i_clk) disable iff (i_sys_rst) (i_wr && i_addr == A_CNT_CLR && i_wdata[0] && !s_ev[0]) |=> scnt_q[0] == 16'h0000;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("start counter not cleared");

  property p_scale_grp;
    @(posedge i_clk) disable iff (i_sys_rst) ctrl_q[CTRL_SCALE] |=> grp_q == 2'h1;
  endproperty
  a_scale_grp: assert property (p_scale_grp) else $error("scaling left group unchanged");

  property p_fac_range;
    @(posedge i_clk) disable iff (i_sys_rst) fac_q >= SCALE_MIN && fac_q <= SCALE_MAX;
  endproperty
  a_fac_range: assert property (p_fac_range) else $error("scale factor out of range");

  property p_copy;
    @(posedge i_clk) disable iff (i_sys_rst) copy |=> pk_q[1][0] == scale_pk($past(pk_q[0][0]), $past(fac_new));
  endproperty
  a_copy: assert property (p_copy) else $error("group two pick-up not scaled copy");

  property p_trip_start;
    @(posedge i_clk) disable iff (i_sys_rst) tr_q[0] |-> st_q[0] && !blk_q[0];
  endproperty
  a_trip_start: assert property (p_trip_start) else $error("trip without start");

  property p_blocked;
    @(posedge i_clk) disable iff (i_sys_rst) i_block[0] |=> !st_q[0];
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked stage started");

  property p_rec_trip;
    @(posedge i_clk) disable iff (i_sys_rst) (rec_hit && t_ev[rec_s]) |=> ri_q[$past(wp_q)][7:0] == PCT_FULL;
  endproperty
  a_rec_trip: assert property (p_rec_trip) else $error("trip record not at full delay");

  property p_rec_adv;
    @(posedge i_clk) disable iff (i_sys_rst) rec_hit |=> wp_q == $past(wp_q) + 3'h1;
  endproperty
  a_rec_adv: assert property (p_rec_adv) else $error("record pointer did not advance");

  c_trip:  cover property (@(posedge i_clk) disable iff (i_sys_rst) t_ev[0]);
  c_fto:   cover property (@(posedge i_clk) disable iff (i_sys_rst) fto);
  c_scale: cover property (@(posedge i_clk) disable iff (i_sys_rst) copy ##1 grp_q == 2'h1);
  c_rec:   cover property (@(posedge i_clk) disable iff (i_sys_rst) rec_hit && !t_ev[rec_s]);
endmodule

// ### dv/remote_master.sv
module remote_master
  import ocs_pkg::*;
(
  input  wire logic        i_clk,   // System clock
  input  wire logic [31:0] i_rdata, // Read data
  output logic      [7:0]  o_addr,  // Register address
  output logic      [31:0] o_wdata, // Write data
  output logic             o_wr,    // Write strobe
  output logic             o_rd     // Read strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_addr  = 8'h00;
    o_wdata = 32'h0;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  // Released data is inverted so a stale sample never looks valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    #1 d = i_rdata;
  endtask
  // One count is one percent; while scaling the active group is forced to two
  task automatic scale(input logic [7:0] pct);
    wr(A_SCALE, {24'h0, pct});
  endtask
endmodule

// ### dv/test_overcurrent_stages.sv
module test_overcurrent_stages
  import ocs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, wr, rd, irq, ff, pp;
  logic [7:0]  addr, di;
  logic [31:0] wdata, rdata, d;
  logic [31:0] ts = 32'h0;
  logic [47:0] fund;
  logic [2:0]  blk, bl, st, tr;
  logic [1:0]  grp;
  int          errors, samples_checked;
  logic [7:0]  row_in[5]  = '{8'h0a, 8'h09, 8'hc8, 8'hc9, 8'h32};
  logic [7:0]  row_exp[5] = '{8'h0a, 8'h0a, 8'hc8, 8'hc8, 8'h32};

  overcurrent_stages #(.TICK_CYCLES(4), .FORCE_TMO_TICKS(8)) uut (
    .i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_phase_fund(fund), .i_phase_rms(fund), .i_block(blk),
    .i_panel_press(pp), .i_digital_input_n(di), .i_virtual_input_n(8'h00),
    .i_indicator_signal_n(8'h00), .i_virtual_output_n(8'h00), .i_timestamp(ts),
    .o_blocked(bl), .o_start(st), .o_trip(tr), .o_active_group(grp), .o_force_flag(ff), .o_irq(irq));
  remote_master m (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) ts <= ts + 32'h1;
  initial
  begin
    #2000000;
    errors++;
    end_sim();
  end

  initial
  begin
    rst = 1'b1; fund = 48'h0; blk = 3'b000; pp = 1'b0; di = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1 chk(grp, 2'h0);
    chk(ff, 1'b0);
    m.rd(A_SCALE, d); chk(d, 32'h64);
    for (int i = 0; i < 5; i++)
    begin
      m.scale(row_in[i]);
      m.rd(A_SCALE, d); chk(d, {24'h0, row_exp[i]});
    end
    // ****************************************
    // Forcing and its timeout
    // ****************************************
    m.wr(A_FORCE, 32'h1);
    m.rd(A_FORCE, d); chk(d, 32'h0);
    m.wr(A_CTRL, 32'h1);
    m.wr(A_FORCE, 32'h1);
    #1 chk(st[0], 1'b1);
    // Panel presses keep renewing the flag, so it must survive well past the timeout
    @(posedge clk) pp <= 1'b1;
    repeat (40) @(posedge clk);
    #1 chk(ff, 1'b1);
    @(posedge clk) pp <= 1'b0;
    repeat (40) @(posedge clk);
    #1 chk(ff, 1'b0);
    chk(st[0], 1'b0);
    m.rd(A_IRQ_STAT, d); chk(d[IRQ_FTO], 1'b1);
    // Selector on digital input bit 0 picks group three, manual group one
    m.wr(A_CTRL, 32'h60);
    @(posedge clk) di <= 8'h01;
    repeat (2) @(posedge clk);
    #1 chk(grp, 2'h2);
    @(posedge clk) di <= 8'h00;
    repeat (2) @(posedge clk);
    #1 chk(grp, 2'h0);
    // ****************************************
    // Scaling, start, trip, counters, records
    // ****************************************
    m.wr(A_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    #1 chk(grp, 2'h1);
    m.rd(8'h50, d); chk(d, 32'h64);
    m.rd(8'he0, d); chk(d, 32'h64);
    @(posedge clk);
    blk <= 3'b010;
    fund <= {16'h0065, 16'h0005, 16'h0005};
    repeat (4) @(posedge clk);
    #1 chk(st, 3'b101);
    chk(bl, 3'b010);
    for (int i = 0; i < 600 && tr[0] !== 1'b1; i++) @(posedge clk);
    chk(tr[0], 1'b1);
    m.rd(8'hc0, d); chk(d, 32'h1);
    m.rd(8'hd0, d); chk(d, 32'h1);
    m.wr(A_CNT_CLR, 32'h1);
    m.rd(8'hc0, d); chk(d, 32'h0);
    m.rd(A_REC_INFO, d); chk(d, 32'h2364);
    m.wr(A_IRQ_MASK, 32'h10);
    #1 chk(irq, 1'b1);
    m.wr(A_IRQ_STAT, 32'h1ff);
    #1 chk(irq, 1'b0);
    // Mid-run reset while stages are tripped must restore the reset state
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk(grp, 2'h0);
    chk(tr, 3'b000);
    chk(ff, 1'b0);
    m.rd(A_SCALE, d); chk(d, 32'h64);
    end_sim();
  end
endmodule
